// ### core/pte_channel.sv
// one clock event channel: compare, target update, event output
`timescale 1ns/1ps
module pte_channel
    import pte_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_sync_b,
    input wire logic [31:0] time_sec,
    input wire logic [31:0] time_ns,
    input wire logic reload,
    input wire logic [1:0] mode,
    input wire logic flag,
    input wire logic wr_sec,
    input wire logic wr_ns,
    input wire logic wr_step_sec,
    input wire logic wr_step_ns,
    input wire logic [31:0] wdata,
    output logic [31:0] tgt_sec,
    output logic [31:0] tgt_ns,
    output logic [31:0] step_sec,
    output logic [31:0] step_ns,
    output logic hit,
    output logic ev_out
);
    logic [7:0] pulse_cnt;
    logic toggle_q;
    logic [32:0] sum_ns;
    logic [31:0] next_ns;
    logic [31:0] next_sec;
    logic armed;

    assign hit = armed && ((time_sec > tgt_sec) ||
        (time_sec == tgt_sec && time_ns >= tgt_ns));

    assign sum_ns = {1'b0, tgt_ns} + {1'b0, step_ns};

    always_comb begin
        next_ns = sum_ns[31:0];
        next_sec = tgt_sec + step_sec;
        if (sum_ns >= {1'b0, NS_PER_SEC}) begin
            next_ns = 32'(sum_ns - {1'b0, NS_PER_SEC});
            next_sec = tgt_sec + step_sec + 32'h1;
        end
    end

    // target writes arm and win over a same-cycle hit; armed clears only on reset, and any other hit moves the target by the step or reloads it
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tgt_sec <= 32'h0;
            tgt_ns <= 32'h0;
            armed <= 1'b0;
        end else if (wr_sec || wr_ns) begin
            if (wr_sec) tgt_sec <= wdata;
            if (wr_ns) tgt_ns <= wdata;
            armed <= 1'b1;
        end else if (hit) begin
            if (reload) begin
                tgt_sec <= step_sec;
                tgt_ns <= step_ns;
            end else begin
                tgt_sec <= next_sec;
                tgt_ns <= next_ns;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            step_sec <= 32'h0;
            step_ns <= 32'h0;
        end else begin
            if (wr_step_sec) step_sec <= wdata;
            if (wr_step_ns) step_ns <= wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pulse_cnt <= 8'h0;
            toggle_q <= 1'b0;
        end else begin
            if (hit) begin
                pulse_cnt <= 8'(PULSE_CYCLES);
                toggle_q <= ~toggle_q;
            end else if (pulse_cnt != 8'h0) begin
                pulse_cnt <= pulse_cnt - 8'h1;
            end
        end
    end

    always_comb begin
        unique case (pte_mode_t'(mode))
            PTE_MODE_PULSE: ev_out = (pulse_cnt != 8'h0);
            PTE_MODE_TOGGLE: ev_out = toggle_q;
            PTE_MODE_FLAG: ev_out = flag;
            PTE_MODE_RSVD: ev_out = 1'b0;
        endcase
    end
endmodule

// ### core/pte_ctrl.sv
// top of the precision clock target event control block
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module pte_ctrl
    import pte_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] gpio_in,
    output logic [2:0] gpio_out,
    output logic [2:0] gpio_oe,
    output logic irq
);
    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta_b;
    logic rst_sync_b;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [31:0] gen_cfg;
    logic [7:0] pin_cfg;
    logic [1:0] status;
    logic [1:0] irq_en;
    logic [31:0] time_sec;
    logic [31:0] time_ns;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [31:0] rd_mux;
    logic [1:0] hit;
    logic [1:0] ev_out;
    logic [1:0] gpio_clr;
    logic [NUM_GPIO-1:0] edge_hit;
    logic [31:0] tgt_sec [2];
    logic [31:0] tgt_ns [2];
    logic [31:0] step_sec [2];
    logic [31:0] step_ns [2];

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    always_comb begin
        addr_ok = 1'b1;
        rd_mux = 32'h0;
        unique case (paddr)
            OFF_GEN_CFG: rd_mux = gen_cfg;
            OFF_IRQ_STATUS: rd_mux = {30'h0, status};
            OFF_IRQ_ENABLE: rd_mux = {30'h0, irq_en};
            OFF_IRQ_CLEAR: rd_mux = 32'h0;
            OFF_TGT_SEC_A: rd_mux = tgt_sec[0];
            OFF_TGT_NS_A: rd_mux = tgt_ns[0];
            OFF_STEP_SEC_A: rd_mux = step_sec[0];
            OFF_STEP_NS_A: rd_mux = step_ns[0];
            OFF_TGT_SEC_B: rd_mux = tgt_sec[1];
            OFF_TGT_NS_B: rd_mux = tgt_ns[1];
            OFF_STEP_SEC_B: rd_mux = step_sec[1];
            OFF_STEP_NS_B: rd_mux = step_ns[1];
            OFF_TIME_SEC: rd_mux = time_sec;
            OFF_TIME_NS: rd_mux = time_ns;
            OFF_PIN_CFG: rd_mux = {24'h0, pin_cfg};
            default: addr_ok = 1'b0;
        endcase
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok;
            if (rd_en && !pready) prdata <= rd_mux;
        end
    end

    logic wr_go;
    assign wr_go = wr_en && !pready;

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            gen_cfg <= GEN_CFG_RESET;
            pin_cfg <= PIN_CFG_RESET;
            irq_en <= 2'b00;
        end else if (wr_go) begin
            if (paddr == OFF_GEN_CFG) gen_cfg <= pwdata & GEN_CFG_MASK;
            if (paddr == OFF_PIN_CFG) pin_cfg <= pwdata[7:0];
            if (paddr == OFF_IRQ_ENABLE) irq_en <= pwdata[1:0];
        end
    end

    // free-running precision time, software may set it
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            time_sec <= 32'h0;
            time_ns <= 32'h0;
        end else if (wr_go && paddr == OFF_TIME_SEC) begin
            time_sec <= pwdata;
        end else if (wr_go && paddr == OFF_TIME_NS) begin
            time_ns <= pwdata;
        end else if (time_ns >= NS_PER_SEC - 32'(CLK_PERIOD_PS / 1000)) begin
            time_ns <= 32'h0;
            time_sec <= time_sec + 32'h1;
        end else begin
            time_ns <= time_ns + 32'(CLK_PERIOD_PS / 1000);
        end
    end

    // ------------------------------------------------------------------
    // gpio clear inputs
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_GPIO; g++) begin : g_edge
            pte_gpio_edge u_edge (
                .clk_sys(clk_sys),
                .rst_sync_b(rst_sync_b),
                .pin(gpio_in[g]),
                .pin_polarity(pin_cfg[POS_PIN_POL + g]),
                .edge_hit(edge_hit[g])
            );
        end
    endgenerate

    // select only gpios 0..2; larger codes never clear
    function automatic logic pick(input logic [2:0] sel,
                                  input logic [2:0] hits,
                                  input logic [2:0] dir_in);
        logic r;
        r = 1'b0;
        if (sel < 3'(NUM_GPIO)) begin
            r = hits[sel[1:0]] & dir_in[sel[1:0]];
        end
        return r;
    endfunction

    assign gpio_clr[0] = gen_cfg[POS_CLR_EN_A] &&
        pick(gen_cfg[POS_SEL_A +: 3], edge_hit, pin_cfg[POS_PIN_IN +: 3]);
    assign gpio_clr[1] = gen_cfg[POS_CLR_EN_B] &&
        pick(gen_cfg[POS_SEL_B +: 3], edge_hit, pin_cfg[POS_PIN_IN +: 3]);

    // ------------------------------------------------------------------
    // channels
    // ------------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_chan
            logic [11:0] base;
            assign base = (c == 0) ? OFF_TGT_SEC_A : OFF_TGT_SEC_B;
            pte_channel u_chan (
                .clk_sys(clk_sys),
                .rst_sync_b(rst_sync_b),
                .time_sec(time_sec),
                .time_ns(time_ns),
                .reload(gen_cfg[POS_RELOAD_A + c]),
                .mode(gen_cfg[POS_MODE_A + 2 * c +: 2]),
                .flag(status[c]),
                .wr_sec(wr_go && paddr == base),
                .wr_ns(wr_go && paddr == base + 12'h4),
                .wr_step_sec(wr_go && paddr == base + 12'h8),
                .wr_step_ns(wr_go && paddr == base + 12'hC),
                .wdata(pwdata),
                .tgt_sec(tgt_sec[c]),
                .tgt_ns(tgt_ns[c]),
                .step_sec(step_sec[c]),
                .step_ns(step_ns[c]),
                .hit(hit[c]),
                .ev_out(ev_out[c])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // status and interrupt
    // ------------------------------------------------------------------
    logic [1:0] sw_clr;
    assign sw_clr = (wr_go && (paddr == OFF_IRQ_STATUS ||
        paddr == OFF_IRQ_CLEAR)) ? pwdata[1:0] : 2'b00;

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            status <= 2'b00;
        end else begin
            // write one clears; a hit in the same cycle wins
            status <= (status & ~sw_clr & ~gpio_clr) | hit;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((status & ~sw_clr & ~gpio_clr) | hit) & irq_en);
        end
    end

    // ------------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------------
    // drive pins only when enabled; polarity applied per pin
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            gpio_out <= 3'h0;
            gpio_oe <= 3'h0;
        end else begin
            gpio_oe <= {1'b0, pin_cfg[POS_PIN_OE_B], pin_cfg[POS_PIN_OE_A]};
            gpio_out <= {1'b0,
                ev_out[1] ^ pin_cfg[POS_PIN_POL + 1],
                ev_out[0] ^ pin_cfg[POS_PIN_POL]};
        end
    end
endmodule

// ### core/pte_gpio_edge.sv
// synchroniser and active-edge detector for one gpio clear input
`timescale 1ns/1ps
module pte_gpio_edge
    import pte_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_sync_b,
    input wire logic pin,
    input wire logic pin_polarity,
    output logic edge_hit
);
    logic meta;
    logic sync;
    logic last;
    logic lvl;

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            meta <= 1'b0;
            sync <= 1'b0;
        end else begin
            meta <= pin;
            sync <= meta;
        end
    end

    assign lvl = sync ^ pin_polarity;

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            last <= 1'b0;
        end else begin
            last <= lvl;
        end
    end

    // inactive to active transition of the polarity-corrected level
    assign edge_hit = lvl & ~last;
endmodule

// ### shared/pte_pkg.sv
// constants and types shared by the clock target event control block
package pte_pkg;
    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFF_GEN_CFG = 12'h104;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h108;
    localparam logic [11:0] OFF_IRQ_ENABLE = 12'h10C;
    localparam logic [11:0] OFF_IRQ_CLEAR = 12'h110;
    localparam logic [11:0] OFF_TGT_SEC_A = 12'h120;
    localparam logic [11:0] OFF_TGT_NS_A = 12'h124;
    localparam logic [11:0] OFF_STEP_SEC_A = 12'h128;
    localparam logic [11:0] OFF_STEP_NS_A = 12'h12C;
    localparam logic [11:0] OFF_TGT_SEC_B = 12'h130;
    localparam logic [11:0] OFF_TGT_NS_B = 12'h134;
    localparam logic [11:0] OFF_STEP_SEC_B = 12'h138;
    localparam logic [11:0] OFF_STEP_NS_B = 12'h13C;
    localparam logic [11:0] OFF_TIME_SEC = 12'h140;
    localparam logic [11:0] OFF_TIME_NS = 12'h144;
    localparam logic [11:0] OFF_PIN_CFG = 12'h148;
    // ------------------------------------------------------------------
    // general config field positions
    // ------------------------------------------------------------------
    localparam int POS_RELOAD_A = 0;
    localparam int POS_RELOAD_B = 1;
    localparam int POS_MODE_A = 2;
    localparam int POS_MODE_B = 4;
    localparam int POS_SEL_A = 8;
    localparam int POS_CLR_EN_A = 11;
    localparam int POS_SEL_B = 12;
    localparam int POS_CLR_EN_B = 15;
    localparam int POS_TSU_EN = 16;
    localparam logic [31:0] GEN_CFG_RESET = 32'h0001_0000;
    localparam logic [31:0] GEN_CFG_MASK = 32'h0001_FF3F;
    // pin config: [2:0] polarity, [5:3] input dir, [6] out A en, [7] out B en
    localparam int POS_PIN_POL = 0;
    localparam int POS_PIN_IN = 3;
    localparam int POS_PIN_OE_A = 6;
    localparam int POS_PIN_OE_B = 7;
    localparam logic [7:0] PIN_CFG_RESET = 8'h38;
    localparam int NUM_GPIO = 3;
    localparam logic [31:0] NS_PER_SEC = 32'h3B9A_CA00;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int PULSE_NS = 100;
    localparam int PULSE_CYCLES =
        (PULSE_NS * 1000 + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
    // ------------------------------------------------------------------
    // output modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PTE_MODE_PULSE = 2'b00,
        PTE_MODE_TOGGLE = 2'b01,
        PTE_MODE_FLAG = 2'b10,
        PTE_MODE_RSVD = 2'b11
    } pte_mode_t;
endpackage

// ### verif/pte_ctrl_properties.sv
// concurrent checks on the ports of the clock target event block
`timescale 1ns/1ps
module pte_ctrl_properties
    import pte_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] gpio_out,
    input wire logic [2:0] gpio_oe,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic [1:0] mode_a;
    logic pm;
    int hi_cnt;
    wire wr = psel && penable && pready && pwrite;
    // ------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            mode_a <= 2'h0;
        else if (wr && paddr == OFF_GEN_CFG)
            mode_a <= pwdata[POS_MODE_A +: 2];
    end
    // only pulses that start in pulse mode on a driven pin are timed
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hi_cnt <= 0;
            pm <= 1'b0;
        end else begin
            hi_cnt <= gpio_out[0] ? hi_cnt + 1 : 0;
            if ($rose(gpio_out[0]))
                pm <= (mode_a == 2'h0) && gpio_oe[0];
        end
    end
    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_needs_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_unmapped: assert property (pready && paddr[11:8] != 4'h1 |-> pslverr)
        else $error("unmapped access not refused");
    a_err_not_cfg: assert property (pready && paddr == OFF_GEN_CFG |-> !pslverr)
        else $error("config access refused");
    a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    a_pin2_idle: assert property (!(gpio_oe[2] || gpio_out[2]))
        else $error("unused pin driven");
    a_oe_follows_cfg: assert property (wr && paddr == OFF_PIN_CFG |->
        ##2 gpio_oe[1:0] == $past(pwdata[7:6], 2))
        else $error("pin enable does not follow config");
    a_pulse_width: assert property ($fell(gpio_out[0]) && pm |->
        hi_cnt == PULSE_CYCLES)
        else $error("event pulse width wrong");
    cover property (pslverr);
    cover property ($fell(gpio_out[0]) && pm);
    cover property (irq);
endmodule

// ### verif/pte_gpio_src.sv
// gpio source model: idles each pin and drives one clear pulse
`timescale 1ns/1ps
module pte_gpio_src
    import pte_pkg::*;
(
    input wire logic clk_sys,
    input wire logic go,
    input wire logic [1:0] idx,
    input wire logic [2:0] idle,
    output logic [2:0] pins
);
    // ------------------------------------------------------------
    // pulse timing
    // ------------------------------------------------------------
    logic [3:0] cnt = 4'h0;
    always @(posedge clk_sys) begin
        if (go)
            cnt <= 4'hC;
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
    end
    always_comb begin
        pins = idle;
        if (cnt != 4'h0)
            pins[idx] = ~idle[idx];
    end
endmodule

// ### verif/ptp_clock_target_event_ctrl_tb.sv
// self-checking bench for the clock target event block
`timescale 1ns/1ps
module ptp_clock_target_event_ctrl_tb;
    import pte_pkg::*;
    logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, irq, er, o0, go = 0;
    logic [11:0] paddr = 0, b;
    logic [31:0] pwdata = 0, prdata, rd, t, s;
    logic [2:0] gpio_in, gpio_out, gpio_oe, p, idle = 0;
    logic [1:0] idx = 0;
    int num_errors = 0, checks = 0, seed = 62, cyc = 0, ch, rl, md;
    always #2 clk_sys = ~clk_sys;
    pte_ctrl i_dut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .gpio_in, .gpio_out,
        .gpio_oe, .irq);
    pte_gpio_src i_src (.clk_sys, .go, .idx, .idle, .pins(gpio_in));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic summarize();
        if (num_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string n, input logic [11:0] a,
                         input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask
    // writing a target at or below the clock arms an immediate hit
    task automatic hit(input int c);
        apb(1'b1, OFF_TGT_NS_A + 12'(16 * c), 32'h0);
        repeat (6) @(posedge clk_sys);
    endtask
    function automatic logic [31:0] nxt(input int r, input logic [31:0] t, s);
        logic [31:0] sum;
        sum = t + s;
        if (r != 0)
            return s;
        return (sum >= NS_PER_SEC) ? sum - NS_PER_SEC : sum;
    endfunction
    function automatic logic mexp(input int m, input logic o, late);
        case (m)
            0: return !late;
            1: return !o;
            2: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rdchk("gen_cfg", OFF_GEN_CFG, GEN_CFG_RESET);
        rdchk("pin_cfg", OFF_PIN_CFG, {24'h0, PIN_CFG_RESET});
        apb(1'b1, 12'hFFC, 32'hFFFF_FFFF);
        chk("wr_err", 32'h1, {31'h0, er});
        rdchk("unmapped", 12'hFFC, 32'h0);
        chk("rd_err", 32'h1, {31'h0, er});
        repeat (4) begin
            t = $random(seed);
            apb(1'b1, OFF_GEN_CFG, t);
            rdchk("gen_rand", OFF_GEN_CFG, t & GEN_CFG_MASK);
        end
        apb(1'b1, OFF_TIME_NS, 32'd1000);
        for (int i = 0; i < 4; i++) begin
            ch = i % 2;
            rl = i / 2;
            b = OFF_TGT_SEC_A + 12'(16 * ch);
            s = 32'd5000000 + ($random(seed) & 32'hFFFF);
            t = $random(seed) & 32'hFF;
            apb(1'b1, OFF_IRQ_STATUS, 32'h3);
            apb(1'b1, OFF_GEN_CFG, 32'(rl) << ch);
            apb(1'b1, b + 12'h8, 32'h0);
            apb(1'b1, b + 12'hC, s);
            apb(1'b1, b, 32'h0);
            apb(1'b1, b + 12'h4, t);
            repeat (8) @(posedge clk_sys);
            rdchk("tgt_ns", b + 12'h4, nxt(rl, t, s));
            rdchk("tgt_sec", b, 32'h0);
            apb(1'b0, OFF_IRQ_STATUS, 32'h0);
            chk("hit", 32'h1, {31'h0, rd[ch]});
        end
        hit(0);
        hit(1);
        apb(1'b1, OFF_IRQ_STATUS, 32'h0);
        rdchk("w0_keeps", OFF_IRQ_STATUS, 32'h3);
        chk("irq_off", 32'h0, {31'h0, irq});
        apb(1'b1, OFF_IRQ_ENABLE, 32'h2);
        repeat (2) @(posedge clk_sys);
        chk("irq_on", 32'h1, {31'h0, irq});
        apb(1'b1, OFF_IRQ_STATUS, 32'h2);
        rdchk("w1_clears", OFF_IRQ_STATUS, 32'h1);
        chk("irq_low", 32'h0, {31'h0, irq});
        apb(1'b1, OFF_IRQ_CLEAR, 32'h1);
        rdchk("clr_reg", OFF_IRQ_STATUS, 32'h0);
        rdchk("clr_rd0", OFF_IRQ_CLEAR, 32'h0);
        // enable off, enabled, enabled but pin not an input
        for (int i = 0; i < 9; i++) begin
            p = 3'b1 << (i % 3);
            idle <= p;
            apb(1'b1, OFF_PIN_CFG, {29'h0, p} | (i / 3 == 2 ? 0 : 32'h38));
            // both channels share the same clear enable and select
            apb(1'b1, OFF_GEN_CFG, {16'h0, i / 3 != 0, 3'(i % 3),
                i / 3 != 0, 3'(i % 3), 8'h00});
            hit(0);
            hit(1);
            idx <= 2'(i % 3);
            go <= 1'b1;
            @(posedge clk_sys);
            go <= 1'b0;
            repeat (24) @(posedge clk_sys);
            apb(1'b0, OFF_IRQ_STATUS, 32'h0);
            chk("gpio_clr", {30'h0, {2{i / 3 != 1}}}, {30'h0, rd[1:0]});
        end
        idle <= 3'h0;
        apb(1'b1, OFF_PIN_CFG, 32'hF8);
        for (int i = 0; i < 8; i++) begin
            ch = i / 4;
            md = i % 4;
            apb(1'b1, OFF_IRQ_STATUS, 32'h3);
            apb(1'b1, OFF_GEN_CFG, 32'(md) << (2 + 2 * ch));
            repeat (2) @(posedge clk_sys);
            o0 = gpio_out[ch];
            hit(ch);
            chk("ev_early", mexp(md, o0, 0), gpio_out[ch]);
            repeat (40) @(posedge clk_sys);
            chk("ev_late", mexp(md, o0, 1), gpio_out[ch]);
        end
        summarize();
    end
endmodule
bind pte_ctrl pte_ctrl_properties i_props (.clk_sys, .rst_b, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .gpio_out, .gpio_oe, .irq);
